// file: accel_tap_detector.sv
// single and double tap detector with AHB-Lite register slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
// What this block does
// RULE_01 - slope is half of sample difference
// RULE_02 - host uses 400, 800 or 1600 Hz
// RULE_03 - single tap: rise, fall within shock
// RULE_04 - unlatched interrupt lasts the quiet window
// RULE_05 - latched interrupt held until source read
// RULE_06 - second tap only after quiet, before latency
// RULE_07 - second tap must also fall within shock
// RULE_08 - over-threshold in quiet cancels double sequence
// RULE_09 - latency window starts after quiet ends
// RULE_10 - evaluate only enabled axes
// RULE_11 - compare slope magnitude with 5-bit threshold
// RULE_12 - shock window decode: 4 or code*8
// RULE_13 - quiet window decode: 2 or code*4
// RULE_14 - latency window decode: 16 or code*32
// RULE_15 - route single and double taps separately
// RULE_16 - no tap interrupt while inactive
// RULE_17 - tap source layout, bit 7 zero
// RULE_18 - bit 3 gives tap sign
// RULE_19 - select bit enables double taps
// RULE_20 - latch single or only double by select
// RULE_21 - latch ignored when not routed
// RULE_22 - inactivity after quiet-slope sample count
// RULE_23 - window counters step per sample
// RULE_24 - source flags held until read, then cleared
module accel_tap_detector #(
  parameter int THR_SHIFT = 10  // slope bits dropped so threshold lsb is FS/32
) (
  input  wire logic                sys_clk,     // system clock, 100 MHz
  input  wire logic                reset_n,     // synchronous reset, active low
  input  wire logic                hsel,        // ahb slave select
  input  wire logic [31:0]         haddr,       // ahb address
  input  wire logic [1:0]          htrans,      // ahb transfer type
  input  wire logic                hwrite,      // ahb write
  input  wire logic [2:0]          hsize,       // ahb size
  input  wire logic [31:0]         hwdata,      // ahb write data
  input  wire logic                hready,      // ahb bus ready
  output logic      [31:0]         hrdata,      // ahb read data
  output logic                     hreadyout,   // ahb slave ready
  output logic                     hresp,       // ahb response, always okay
  input  wire logic                sampleValid, // new sample strobe, same clock
  input  wire atd_pkg::atd_sample_t sampleIn,   // signed x, y, z samples
  output logic                     accelIrqPin1 // tap interrupt on pin one
);
  import atd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SHOCK1, ST_QUIET, ST_LAT, ST_SHOCK2} atd_state_t;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [7:0] ctrlThree_q, pinRouting_q, threshold_q, durations_q, motion_q;
  logic [6:0] source_q;
  logic       wrPend_q;
  logic [7:0] wrAddr_q;
  logic       addrPhase;
  logic       rdSrcNow;
  assign addrPhase = hsel && htrans[1] && hready;
  // source clear rides on the same edge that captures the read data, so an event
  // landing between capture and clear can never be wiped unseen
  assign rdSrcNow  = addrPhase && !hwrite && (haddr[7:0] == REG_TAP_SOURCE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end
    else
    begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ctrlThree_q  <= 8'h00;
      pinRouting_q <= 8'h00;
      threshold_q  <= 8'h00;
      durations_q  <= 8'h00;
      motion_q     <= 8'h00;
    end
    else if (wrPend_q)
    begin
      unique case (wrAddr_q)
        REG_CTRL_THREE:   ctrlThree_q  <= hwdata[7:0];
        REG_PIN1_ROUTING: pinRouting_q <= hwdata[7:0];
        REG_THRESHOLD:    threshold_q  <= hwdata[7:0];
        REG_DURATIONS:    durations_q  <= hwdata[7:0];
        REG_MOTION:       motion_q     <= hwdata[7:0];
        default:          ;
      endcase
    end
  end

  // read data registered in the address phase; source clear on the same edge
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      if (addrPhase && !hwrite)
      begin
        unique case (haddr[7:0])
          REG_CTRL_THREE:   hrdata <= {24'h00_0000, ctrlThree_q};
          REG_PIN1_ROUTING: hrdata <= {24'h00_0000, pinRouting_q};
          REG_THRESHOLD:    hrdata <= {24'h00_0000, threshold_q};
          REG_DURATIONS:    hrdata <= {24'h00_0000, durations_q};
          REG_MOTION:       hrdata <= {24'h00_0000, motion_q};
          REG_TAP_SOURCE:   hrdata <= {25'h000_0000, source_q}; // [RULE_17]
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // slope and threshold
  // ----------------------------------------------------------------
  function automatic logic [9:0] decodeWin(input logic [3:0] code, input logic [9:0] zeroLen,
                                           input logic [9:0] unit);
    decodeWin = (code == 4'h0) ? zeroLen : 10'((unit * code));
  endfunction : decodeWin

  function automatic logic [SAMPLE_W:0] slopeOf(input logic [SAMPLE_W-1:0] cur,
                                                input logic [SAMPLE_W-1:0] prev);
    logic signed [SAMPLE_W:0] diff;
    diff = $signed({cur[SAMPLE_W-1], cur}) - $signed({prev[SAMPLE_W-1], prev});
    slopeOf = diff >>> 1; // [RULE_01]
  endfunction : slopeOf

  function automatic logic overThr(input logic [SAMPLE_W:0] slope, input logic [4:0] thr);
    logic [SAMPLE_W:0] mag;
    mag = slope[SAMPLE_W] ? (SAMPLE_W+1)'(-slope) : slope;
    overThr = (mag >> THR_SHIFT) > {{(SAMPLE_W-4){1'b0}}, thr}; // [RULE_11]
  endfunction : overThr

  atd_sample_t prev_q;
  logic        primed_q;
  logic [SAMPLE_W:0] slopeX, slopeY, slopeZ;
  logic [2:0]  axisOver;
  logic        anyOver;
  assign slopeX = slopeOf(sampleIn.x, prev_q.x);
  assign slopeY = slopeOf(sampleIn.y, prev_q.y);
  assign slopeZ = slopeOf(sampleIn.z, prev_q.z);
  assign axisOver = {overThr(slopeX, threshold_q[4:0]) && ctrlThree_q[CTL_XEN],
                     overThr(slopeY, threshold_q[4:0]) && ctrlThree_q[CTL_YEN],
                     overThr(slopeZ, threshold_q[4:0]) && ctrlThree_q[CTL_ZEN]}; // [RULE_10]
  assign anyOver = sampleValid && primed_q && (axisOver != 3'b000);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end
    else if (sampleValid)
    begin
      prev_q   <= sampleIn;
      primed_q <= 1'b1;
    end
  end

  logic [9:0] shockLen, quietLen, latLen;
  assign shockLen = decodeWin({2'b00, durations_q[DUR_SHOCK_LO +: 2]}, SHOCK_ZERO, SHOCK_UNIT); // [RULE_12]
  assign quietLen = decodeWin({2'b00, durations_q[DUR_QUIET_LO +: 2]}, QUIET_ZERO, QUIET_UNIT); // [RULE_13]
  assign latLen   = decodeWin(durations_q[DUR_LAT_LO +: 4], LAT_ZERO, LAT_UNIT);              // [RULE_14]

  // ----------------------------------------------------------------
  // inactivity: slopes below motion threshold for sleep count
  // ----------------------------------------------------------------
  logic [15:0] quietRun_q;
  logic        inactive_q;
  logic        motionOver;
  assign motionOver = (overThr(slopeX, 5'(motion_q[5:1])) || overThr(slopeY, 5'(motion_q[5:1]))
                       || overThr(slopeZ, 5'(motion_q[5:1])));
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      quietRun_q <= 16'h0000;
      inactive_q <= 1'b0;
    end
    else if (sampleValid && primed_q)
    begin
      if (motionOver || !motion_q[MOT_SLEEP])
      begin
        quietRun_q <= 16'h0000;
        inactive_q <= 1'b0;
      end
      else if (quietRun_q >= SLEEP_UNIT - 16'h0001)
        inactive_q <= 1'b1; // [RULE_22]
      else
        quietRun_q <= quietRun_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // tap state machine
  // ----------------------------------------------------------------
  atd_state_t state_q;
  logic [9:0] winCnt_q;
  logic [2:0] tapAxis_q;
  logic       tapNeg_q;
  logic       doubleOn, singleEvt, doubleEvt;
  logic       firstNeg;
  assign doubleOn = motion_q[MOT_DOUBLE];
  assign firstNeg = axisOver[2] ? slopeX[SAMPLE_W] : axisOver[1] ? slopeY[SAMPLE_W]
                    : slopeZ[SAMPLE_W];

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_q   <= ST_IDLE;
      winCnt_q  <= 10'h000;
      tapAxis_q <= 3'b000;
      tapNeg_q  <= 1'b0;
    end
    else if (sampleValid && primed_q)
    begin
      winCnt_q <= winCnt_q + 10'h001; // [RULE_23]
      unique case (state_q)
        ST_IDLE:
          if (anyOver)
          begin
            state_q   <= ST_SHOCK1;
            winCnt_q  <= 10'h001;
            tapAxis_q <= axisOver;
            tapNeg_q  <= firstNeg; // [RULE_18]
          end
        ST_SHOCK1, ST_SHOCK2:
          if (!anyOver)
          begin
            state_q  <= (state_q == ST_SHOCK1 && doubleOn) ? ST_QUIET : ST_IDLE;
            winCnt_q <= 10'h000;
          end
          else if (winCnt_q >= shockLen)
            state_q <= ST_IDLE; // [RULE_03] [RULE_07]
        ST_QUIET:
          if (anyOver)
            state_q <= ST_IDLE; // [RULE_08]
          else if (winCnt_q + 10'h001 >= quietLen)
          begin
            state_q  <= ST_LAT; // [RULE_09]
            winCnt_q <= 10'h000;
          end
        ST_LAT:
          if (anyOver)
          begin
            state_q   <= ST_SHOCK2; // [RULE_06]
            winCnt_q  <= 10'h001;
            tapAxis_q <= axisOver;
            tapNeg_q  <= firstNeg;
          end
          else if (winCnt_q + 10'h001 >= latLen)
            state_q <= ST_IDLE;
      endcase
    end
  end

  assign singleEvt = sampleValid && primed_q && state_q == ST_SHOCK1 && !anyOver;
  assign doubleEvt = sampleValid && primed_q && state_q == ST_SHOCK2 && !anyOver
                     && doubleOn; // [RULE_19]

  // ----------------------------------------------------------------
  // source flags and interrupt output
  // ----------------------------------------------------------------
  // a new event wins over the read clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      source_q <= 7'h00;
    else if (singleEvt || doubleEvt)
    begin
      source_q[SRC_ANY] <= 1'b1;
      source_q[SRC_ONE] <= singleEvt || (source_q[SRC_ONE] && !rdSrcNow);
      source_q[SRC_TWO] <= doubleEvt || (source_q[SRC_TWO] && !rdSrcNow);
      source_q[SRC_NEG] <= tapNeg_q;
      source_q[SRC_X]   <= tapAxis_q[2];
      source_q[SRC_Y]   <= tapAxis_q[1];
      source_q[SRC_Z]   <= tapAxis_q[0];
    end
    else if (rdSrcNow)
      source_q <= 7'h00; // [RULE_24]
  end

  logic routeOne, routeTwo, latchEff;
  logic [9:0] pulseCnt_q;
  logic       pulse_q, latched_q;
  assign routeOne = pinRouting_q[ROUTE_ONE];
  assign routeTwo = pinRouting_q[ROUTE_TWO];
  assign latchEff = ctrlThree_q[CTL_LATCH] && (routeOne || routeTwo); // [RULE_21]

  logic evtRouted, evtLatch;
  assign evtRouted = !inactive_q && ((singleEvt && routeOne) || (doubleEvt && routeTwo)); // [RULE_15] [RULE_16]
  assign evtLatch  = latchEff && (doubleOn ? doubleEvt : singleEvt); // [RULE_20]

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pulse_q    <= 1'b0;
      pulseCnt_q <= 10'h000;
      latched_q  <= 1'b0;
    end
    else
    begin
      if (evtRouted && evtLatch)
        latched_q <= 1'b1; // [RULE_05]
      else if (rdSrcNow)
        latched_q <= 1'b0;
      if (evtRouted && !evtLatch)
      begin
        pulse_q    <= 1'b1;
        pulseCnt_q <= 10'h000;
      end
      else if (pulse_q && sampleValid)
      begin
        pulseCnt_q <= pulseCnt_q + 10'h001;
        if (pulseCnt_q + 10'h001 >= quietLen)
          pulse_q <= 1'b0; // [RULE_04]
      end
    end
  end

  assign accelIrqPin1 = (pulse_q || latched_q) && !inactive_q;

  AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    latched_q && !rdSrcNow |=> latched_q) else $error("latched irq dropped"); // [RULE_05]
  AST_READ_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdSrcNow && !singleEvt && !doubleEvt |=> source_q == 7'h00)
    else $error("source not cleared"); // [RULE_24]
  AST_INACTIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    inactive_q |-> !accelIrqPin1) else $error("irq while inactive"); // [RULE_16]
  AST_NO_DOUBLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !doubleOn && !source_q[SRC_TWO] |=> !source_q[SRC_TWO])
    else $error("double tap in single mode"); // [RULE_19]
  AST_QUIET_CANCEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_QUIET && anyOver |=> state_q == ST_IDLE) else $error("quiet not cancelled"); // [RULE_08]
  AST_SHOCK_BOUND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_SHOCK1 |-> winCnt_q <= shockLen) else $error("shock overrun"); // [RULE_03]
  AST_SINGLE_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
    singleEvt |=> source_q[SRC_ONE] && source_q[SRC_ANY]) else $error("single flag missing"); // [RULE_17]
  AST_NOT_ROUTED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !routeOne && !routeTwo |-> !evtRouted) else $error("unrouted event drove pin"); // [RULE_21]

  // ----------------------------------------------------------------
  // sequencing checks
  // ----------------------------------------------------------------
  // a tap closes on the first valid sample that is back under threshold
  sequence sqTapDone;
    sampleValid && primed_q && !anyOver;
  endsequence

  // latency can only follow quiet; a jump from shock would skip the bounce guard
  AST_LAT_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_LAT && $past(state_q) != ST_LAT |-> $past(state_q) == ST_QUIET)
    else $error("latency not after quiet"); // [RULE_09]
  AST_SHOCK2_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_SHOCK2 && $past(state_q) != ST_SHOCK2 |-> $past(state_q) == ST_LAT)
    else $error("second tap outside latency"); // [RULE_06]
  AST_DOUBLE_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_SHOCK2 && doubleOn) ##0 sqTapDone |=> source_q[SRC_TWO])
    else $error("double flag missing"); // [RULE_07]
  AST_PULSE_DROP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pulse_q && sampleValid && !evtRouted && pulseCnt_q + 10'h001 >= quietLen |=> !pulse_q)
    else $error("pulse outlasts quiet window"); // [RULE_04]
  AST_PULSE_SRC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pulse_q && !evtRouted |=> !pulse_q) else $error("pulse without routed event"); // [RULE_15]
endmodule : accel_tap_detector

// file: atd_pkg.sv
// package for the accelerometer tap detector: register map, fields, window scales
package atd_pkg;
  localparam logic [7:0] REG_CTRL_THREE   = 8'h00;
  localparam logic [7:0] REG_PIN1_ROUTING = 8'h04;
  localparam logic [7:0] REG_THRESHOLD    = 8'h08;
  localparam logic [7:0] REG_DURATIONS    = 8'h0C;
  localparam logic [7:0] REG_MOTION       = 8'h10;
  localparam logic [7:0] REG_TAP_SOURCE   = 8'h38;
  // control bits of accel_control_three
  localparam int CTL_LATCH = 2;
  localparam int CTL_ZEN   = 3;
  localparam int CTL_YEN   = 4;
  localparam int CTL_XEN   = 5;
  // pin-one routing bits
  localparam int ROUTE_TWO = 3;
  localparam int ROUTE_ONE = 6;
  // motion register: double-tap select, sleep enable
  localparam int MOT_DOUBLE = 7;
  localparam int MOT_SLEEP  = 6;
  // duration register fields
  localparam int DUR_SHOCK_LO = 0;
  localparam int DUR_QUIET_LO = 2;
  localparam int DUR_LAT_LO   = 4;
  // window scales in sample periods
  localparam logic [9:0] SHOCK_ZERO = 10'h004;
  localparam logic [9:0] SHOCK_UNIT = 10'h008;
  localparam logic [9:0] QUIET_ZERO = 10'h002;
  localparam logic [9:0] QUIET_UNIT = 10'h004;
  localparam logic [9:0] LAT_ZERO   = 10'h010;
  localparam logic [9:0] LAT_UNIT   = 10'h020;
  localparam logic [15:0] SLEEP_UNIT = 16'h0200;
  // tap source bits
  localparam int SRC_ANY = 6;
  localparam int SRC_ONE = 5;
  localparam int SRC_TWO = 4;
  localparam int SRC_NEG = 3;
  localparam int SRC_X   = 2;
  localparam int SRC_Y   = 1;
  localparam int SRC_Z   = 0;
  localparam int SAMPLE_W = 16;
  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z;
  } atd_sample_t;
endpackage : atd_pkg

// file: atd_host.sv
// host processor model: ahb-lite master that reaches the tap detector registers
`timescale 1ns/1ps
module atd_host (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        hreadyout, // slave ready, also the bus ready
  input  wire logic [31:0] hrdata,    // read data
  output logic             hsel,      // slave select
  output logic      [31:0] haddr,     // byte address
  output logic      [1:0]  htrans,    // transfer type
  output logic             hwrite,    // write strobe
  output logic      [2:0]  hsize,     // transfer size
  output logic      [31:0] hwdata     // write data
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // -----------------------------------------------------------------
  // single whole-word transfer; call right after a rising edge
  // -----------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    // address taken: release it, then hold write data through the data phase
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : xfer
endmodule : atd_host

// file: accel_tap_detector_tb.sv
// self-checking bench for the accelerometer tap detector
`timescale 1ns/1ps
module accel_tap_detector_tb;
  import atd_pkg::*;
  typedef struct {
    logic [7:0] ctl, rte, thr, dur, mot;
    int         axis, neg, hold, gap, pre;
    logic [7:0] src;
    int         irqs;
  } atd_row_t;
  // clocks per sample: a scaled-down 400 Hz output rate
  localparam int SP = 4;
  logic        sys_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        sampleValid = 1'b0;
  atd_sample_t sampleIn    = '0;
  logic        hsel, hwrite, hreadyout, hresp, accelIrqPin1;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] acc = '0;
  int          n_mismatch = 0, n_checks = 0, cycles = 0, irqCnt = 0;
  // ctl rte thr dur mot axis neg hold gap pre src irqs
  atd_row_t    rows[15] = '{
    '{8'h38, 8'h40, 8'h00, 8'h00, 8'h00, 0, 0, 1, -1, 0, 8'h64, 2},
    '{8'h38, 8'h40, 8'h00, 8'h00, 8'h00, 1, 1, 1, -1, 0, 8'h6A, 2},
    '{8'h38, 8'h40, 8'h00, 8'h04, 8'h00, 2, 0, 1, -1, 0, 8'h61, 4},
    '{8'h30, 8'h40, 8'h00, 8'h00, 8'h00, 2, 0, 1, -1, 0, 8'h00, 0},
    '{8'h38, 8'h40, 8'h01, 8'h00, 8'h00, 0, 0, 1, -1, 0, 8'h00, 0},
    '{8'h38, 8'h40, 8'h00, 8'h00, 8'h00, 0, 0, 5, -1, 0, 8'h00, 0},
    '{8'h38, 8'h40, 8'h00, 8'h01, 8'h00, 0, 0, 5, -1, 0, 8'h64, 2},
    '{8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 1, -1, 0, 8'h64, 0},
    '{8'h38, 8'h08, 8'h00, 8'h00, 8'h80, 0, 0, 1, 5, 0, 8'h74, 2},
    '{8'h38, 8'h08, 8'h00, 8'h00, 8'h80, 0, 0, 1, 30, 0, 8'h64, 0},
    '{8'h38, 8'h08, 8'h00, 8'h10, 8'h80, 0, 0, 1, 30, 0, 8'h74, 2},
    '{8'h38, 8'h08, 8'h00, 8'h00, 8'h80, 0, 0, 1, 0, 0, 8'h64, 0},
    '{8'h38, 8'h48, 8'h00, 8'h00, 8'h00, 0, 0, 1, 5, 0, 8'h64, 4},
    '{8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 1, -1, 0, 8'h64, 0},
    '{8'h38, 8'h40, 8'h00, 8'h00, 8'h7E, 0, 0, 1, -1, 520, 8'h64, 0}};

  always #5 sys_clk = ~sys_clk;

  accel_tap_detector i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleValid(sampleValid),
    .sampleIn(sampleIn), .accelIrqPin1(accelIrqPin1));
  atd_host i_host (.sys_clk(sys_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // -----------------------------------------------------------------
  // report and compare
  // -----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: register %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(logic got, logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: interrupt %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(int got, int exp);
    n_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: pulse samples %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // stimulus tasks, each entered right after a rising edge
  // -----------------------------------------------------------------
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_host.xfer(a, 1'b1, {24'h00_0000, d}, rdv);
  endtask : wr

  task automatic rd(logic [7:0] a);
    i_host.xfer(a, 1'b0, 32'h0000_0000, rdv);
  endtask : rd

  // one sample slot; the pin is looked at once per slot
  task automatic send(int axis);
    atd_sample_t s;
    s = '0;
    if (axis == 0) s.x = acc;
    if (axis == 1) s.y = acc;
    if (axis == 2) s.z = acc;
    sampleValid <= 1'b1;
    sampleIn    <= s;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
    repeat (SP - 1) @(posedge sys_clk);
    if (accelIrqPin1 === 1'b1) irqCnt++;
  endtask : send

  // ramp for hold samples (slope over a zero threshold), then one flat sample
  task automatic tap(int axis, int neg, int hold);
    repeat (hold)
    begin
      acc = neg ? acc - 16'h0C00 : acc + 16'h0C00;
      send(axis);
    end
    send(axis);
  endtask : tap

  // axes off while the level returns to zero, so no stale slope looks like a tap
  task automatic cfg(atd_row_t r);
    wr(REG_CTRL_THREE, 8'h00);
    acc = '0;
    send(0);
    rd(REG_TAP_SOURCE);
    wr(REG_CTRL_THREE, r.ctl);
    wr(REG_PIN1_ROUTING, r.rte);
    wr(REG_THRESHOLD, r.thr);
    wr(REG_DURATIONS, r.dur);
    wr(REG_MOTION, r.mot);
    irqCnt = 0;
  endtask : cfg

  task automatic run_row(atd_row_t r);
    cfg(r);
    repeat (r.pre + 1) send(r.axis);
    tap(r.axis, r.neg, r.hold);
    if (r.gap >= 0)
    begin
      repeat (r.gap) send(r.axis);
      tap(r.axis, r.neg, 1);
    end
    repeat (40) send(r.axis);
    rd(REG_TAP_SOURCE);
    chk_reg(rdv, {24'h00_0000, r.src});
    chk_cnt(irqCnt, r.irqs);
    chk_bit(hresp, 1'b0);
  endtask : run_row

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    atd_row_t r;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 14; i++) run_row(rows[i]);
    r = rows[0];
    r.ctl = 8'h3C;
    cfg(r);
    tap(0, 0, 1);
    repeat (20) send(0);
    chk_bit(accelIrqPin1, 1'b1);
    rd(REG_TAP_SOURCE);
    chk_reg(rdv, 32'h0000_0064);
    repeat (2) @(posedge sys_clk);
    chk_bit(accelIrqPin1, 1'b0);
    rd(REG_TAP_SOURCE);
    chk_reg(rdv, 32'h0000_0000);
    // double mode latches only the double tap, so a lone single tap still pulses
    r.rte = 8'h48;
    r.mot = 8'h80;
    cfg(r);
    tap(0, 0, 1);
    repeat (40) send(0);
    chk_cnt(irqCnt, 2);
    run_row(rows[14]);
    wr(REG_DURATIONS, 8'hA5);
    rd(REG_DURATIONS);
    chk_reg(rdv, 32'h0000_00A5);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(REG_DURATIONS);
    chk_reg(rdv, 32'h0000_0000);
    rd(8'h20);
    chk_reg(rdv, 32'h0000_0000);
    give_verdict();
  end
endmodule : accel_tap_detector_tb
